// file: logic/mtc_timer_carrier.v
// Interval timer with modulo compare and infrared carrier generator.
// Assumes one clock at 200 MHz taken as 2fx, and a same-domain register port.
//
// Overview of operation
// - Timer has 8-bit counter, 8-bit modulo, comparator and clock selector.
// - Control at 33H: bit 3 runs timer, bit 2 clears counter.
// - Bits 1..0 of 33H pick fx/32, fx/64, fx/256 or one tick per carrier period.
// - Counter is readable; writes never load it.
// - Modulo register is write-only; reads return zero.
// - Count equal to a nonzero modulo sets interrupt flag 3FH bit 0.
// - Clear bit acts only on write and reads back zero.
// - CPU speed mode switches fastest timer resolution between 16 and 32 fx.
// - Carrier uses one 8-bit counter with high and low period registers.
// - Bits 1..0 of 13H select carrier clock fx/2, fx or 2fx.
// - Both carrier period registers are writable and readable.
// - 12H bit 1 chooses carrier output (0) or steady high.
// - Gate 1 passes carrier to pin; gate 0 drives low, halts generator.
// - Each timer match copies gate buffer bit into gate bit.
// - Gate turn-off during high carrier phase waits until carrier goes low; turn-on takes effect at once.
// - Each carrier phase lasts period value plus one carrier clocks.
`include "mtc_map.vh"
`timescale 1ns/1ps

module mtc_timer_carrier (
  input wire core_clk_i,
  input wire reset_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rdata_o,
  input wire stop_mode_i,
  output wire irq_o,
  output wire interval_match_o,
  output wire carrier_out_pin_o
);

  ////////////////////////////////////////////////////////////////////////
  // Register state

  reg interval_run_r;
  reg [1:0] interval_clksel_r;
  reg [7:0] interval_counter_r;
  reg [7:0] interval_modulo_r;
  reg interval_irq_flag_r;
  reg irq_mask_r;
  reg cpu_speed_select_r;
  reg output_gate_buffer_r;
  reg output_gate_r;
  reg carrier_suppress_r;
  reg [1:0] carrier_clksel_r;
  reg [7:0] carrier_high_period_r;
  reg [7:0] carrier_low_period_r;
  reg [7:0] prescale_r;
  reg [7:0] carrier_cnt_r;
  reg carrier_phase_r;
  reg pin_gate_r;
  reg pin_r;
  reg [7:0] rdata_r;
  reg match_r;

  wire wr_ctrl;
  wire wr_status;
  wire wr_gate;
  wire fx_tick;
  wire half_fx_tick;
  wire carrier_tick;
  wire carrier_period_end;
  wire timer_tick;
  wire match_event;
  wire carrier_run;
  wire [7:0] fast_mask;
  reg [7:0] sel_mask;
  reg [7:0] rdata_nxt;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == `MTC_ADDR_TMR_CTRL);
  assign wr_status = reg_wr_i && (reg_addr_i == `MTC_ADDR_IRQ_STATUS);
  assign wr_gate = reg_wr_i && (reg_addr_i == `MTC_ADDR_GATE_CTRL);

  ////////////////////////////////////////////////////////////////////////
  // Clock enables derived from the 2fx core clock

  mtc_tick_div #(
    .DIV(`MTC_CORE_PER_FX),
    .W(3)
  ) u_fx_div (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .tick_o(fx_tick)
  );

  mtc_tick_div #(
    .DIV(`MTC_CORE_PER_HALF_FX),
    .W(3)
  ) u_half_fx_div (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .tick_o(half_fx_tick)
  );

  // Carrier clock select; the unused code falls back to fx
  assign carrier_tick = (carrier_clksel_r == `MTC_CSEL_HALF) ? half_fx_tick :
                        (carrier_clksel_r == `MTC_CSEL_DOUBLE) ? 1'b1 :
                        fx_tick;

  ////////////////////////////////////////////////////////////////////////
  // Timer prescaler and clock selector

  // High-speed CPU mode halves the finest resolution
  assign fast_mask = cpu_speed_select_r ? `MTC_MASK_DIV16 : `MTC_MASK_DIV32;

  always @*
  begin
    case (interval_clksel_r)
      `MTC_TSEL_DIV32: sel_mask = fast_mask;
      `MTC_TSEL_DIV64: sel_mask = `MTC_MASK_DIV64;
      `MTC_TSEL_DIV256: sel_mask = `MTC_MASK_DIV256;
      default: sel_mask = `MTC_MASK_DIV256;
    endcase
  end

  assign timer_tick = (interval_clksel_r == `MTC_TSEL_CARRIER) ? carrier_period_end :
                      (fx_tick && ((prescale_r & sel_mask) == sel_mask));

  // Prescaler runs regardless of the run bit and is reset only by reset_i and the clear bit, so a resolution change only shifts the next tick
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      prescale_r <= `MTC_RST_BYTE;
    end
    else if (wr_ctrl && reg_wdata_i[`MTC_BIT_CLEAR])
    begin
      prescale_r <= `MTC_RST_BYTE;
    end
    else if (fx_tick)
    begin
      prescale_r <= prescale_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interval counter and compare

  // Zero modulo never flags, so software cannot fake a match
  assign match_event = interval_run_r && timer_tick &&
                       (interval_counter_r == interval_modulo_r) &&
                       (interval_modulo_r != 8'h00);

  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      interval_counter_r <= `MTC_RST_BYTE;
    end
    else if (wr_ctrl && reg_wdata_i[`MTC_BIT_CLEAR])
    begin
      interval_counter_r <= `MTC_RST_BYTE;
    end
    else if (interval_run_r && timer_tick)
    begin
      if (interval_counter_r == interval_modulo_r)
      begin
        interval_counter_r <= `MTC_RST_BYTE;
      end
      else
      begin
        interval_counter_r <= interval_counter_r + 8'h01;
      end
    end
  end

  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      interval_run_r <= 1'b0;
      interval_clksel_r <= `MTC_RST_CLKSEL;
    end
    else if (stop_mode_i)
    begin
      // STOP drops the run bit; software restarts it afterwards
      interval_run_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      interval_run_r <= reg_wdata_i[`MTC_BIT_RUN];
      interval_clksel_r <= reg_wdata_i[`MTC_BIT_CLKSEL_HI:`MTC_BIT_CLKSEL_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software-written registers

  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      interval_modulo_r <= `MTC_RST_BYTE;
      carrier_high_period_r <= `MTC_RST_BYTE;
      carrier_low_period_r <= `MTC_RST_BYTE;
      carrier_clksel_r <= `MTC_RST_CLKSEL;
      cpu_speed_select_r <= 1'b0;
      output_gate_buffer_r <= 1'b0;
      carrier_suppress_r <= 1'b0;
      irq_mask_r <= 1'b0;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `MTC_ADDR_MODULO: interval_modulo_r <= reg_wdata_i;
        `MTC_ADDR_CARR_HIGH: carrier_high_period_r <= reg_wdata_i;
        `MTC_ADDR_CARR_LOW: carrier_low_period_r <= reg_wdata_i;
        `MTC_ADDR_CARR_CLKSEL: carrier_clksel_r <= reg_wdata_i[1:0];
        `MTC_ADDR_CPU_SPEED: cpu_speed_select_r <= reg_wdata_i[`MTC_BIT_SPEED];
        `MTC_ADDR_GATE_BUF: output_gate_buffer_r <= reg_wdata_i[`MTC_BIT_GATE_BUF];
        `MTC_ADDR_GATE_CTRL: carrier_suppress_r <= reg_wdata_i[`MTC_BIT_SUPPRESS];
        `MTC_ADDR_IRQ_MASK: irq_mask_r <= reg_wdata_i[`MTC_BIT_IRQ_FLAG];
        default: irq_mask_r <= irq_mask_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flag, gate bit and match pulse

  // A match in the clearing cycle wins over the write-one clear
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      interval_irq_flag_r <= 1'b0;
      match_r <= 1'b0;
    end
    else
    begin
      match_r <= match_event;
      if (match_event)
      begin
        interval_irq_flag_r <= 1'b1;
      end
      else if (wr_status && reg_wdata_i[`MTC_BIT_IRQ_FLAG])
      begin
        interval_irq_flag_r <= 1'b0;
      end
    end
  end

  assign irq_o = interval_irq_flag_r && irq_mask_r;
  assign interval_match_o = match_r;

  // Hardware transfer on a match takes priority over a direct write
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      output_gate_r <= 1'b0;
    end
    else if (match_event)
    begin
      output_gate_r <= output_gate_buffer_r;
    end
    else if (wr_gate)
    begin
      output_gate_r <= reg_wdata_i[`MTC_BIT_GATE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Carrier generator

  // Runs while either the gate or the held pin gate is on
  assign carrier_run = output_gate_r || pin_gate_r;
  assign carrier_period_end = carrier_run && carrier_tick && !carrier_phase_r &&
                              (carrier_cnt_r == carrier_low_period_r);

  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      carrier_cnt_r <= `MTC_RST_BYTE;
      carrier_phase_r <= 1'b1;
    end
    else if (!carrier_run)
    begin
      // Halted generator restarts with a full high phase
      carrier_cnt_r <= `MTC_RST_BYTE;
      carrier_phase_r <= 1'b1;
    end
    else if (carrier_tick)
    begin
      if (carrier_cnt_r == (carrier_phase_r ? carrier_high_period_r : carrier_low_period_r))
      begin
        carrier_cnt_r <= `MTC_RST_BYTE;
        carrier_phase_r <= !carrier_phase_r;
      end
      else
      begin
        carrier_cnt_r <= carrier_cnt_r + 8'h01;
      end
    end
  end

  // The pin gate follows the gate bit except mid high pulse
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      pin_gate_r <= 1'b0;
    end
    else if (!(pin_gate_r && carrier_phase_r))
    begin
      pin_gate_r <= output_gate_r;
    end
  end

  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      pin_r <= 1'b0;
    end
    else if (carrier_suppress_r)
    begin
      pin_r <= 1'b1;
    end
    else
    begin
      pin_r <= pin_gate_r && carrier_phase_r;
    end
  end

  assign carrier_out_pin_o = pin_r;

  ////////////////////////////////////////////////////////////////////////
  // Read path: data stands in the cycle after the strobe only

  always @*
  begin
    rdata_nxt = `MTC_RST_BYTE;
    case (reg_addr_i)
      `MTC_ADDR_TMR_CTRL: rdata_nxt = {4'h0, interval_run_r, 1'b0, interval_clksel_r};
      `MTC_ADDR_COUNTER: rdata_nxt = interval_counter_r;
      `MTC_ADDR_MODULO: rdata_nxt = `MTC_RST_BYTE;
      `MTC_ADDR_IRQ_STATUS: rdata_nxt = {7'h00, interval_irq_flag_r};
      `MTC_ADDR_IRQ_MASK: rdata_nxt = {7'h00, irq_mask_r};
      `MTC_ADDR_CARR_HIGH: rdata_nxt = carrier_high_period_r;
      `MTC_ADDR_CARR_LOW: rdata_nxt = carrier_low_period_r;
      `MTC_ADDR_CARR_CLKSEL: rdata_nxt = {6'h00, carrier_clksel_r};
      `MTC_ADDR_GATE_CTRL: rdata_nxt = {6'h00, carrier_suppress_r, output_gate_r};
      `MTC_ADDR_GATE_BUF: rdata_nxt = {7'h00, output_gate_buffer_r};
      `MTC_ADDR_CPU_SPEED: rdata_nxt = {7'h00, cpu_speed_select_r};
      default: rdata_nxt = `MTC_RST_BYTE;
    endcase
  end

  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rdata_r <= `MTC_RST_BYTE;
    end
    else if (reg_rd_i)
    begin
      rdata_r <= rdata_nxt;
    end
    else
    begin
      rdata_r <= `MTC_RST_BYTE;
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule

// file: include/mtc_map.vh
// Register map, field positions and reset values of the interval timer
// and carrier generator. Included by the design files by bare name.
`ifndef MTC_MAP_VH
`define MTC_MAP_VH

// Register addresses, one byte each on the 8-bit register port
`define MTC_ADDR_CPU_SPEED    8'h02
`define MTC_ADDR_GATE_BUF     8'h11
`define MTC_ADDR_GATE_CTRL    8'h12
`define MTC_ADDR_CARR_CLKSEL  8'h13
`define MTC_ADDR_TMR_CTRL     8'h33
`define MTC_ADDR_IRQ_STATUS   8'h3F
`define MTC_ADDR_IRQ_MASK     8'h40
`define MTC_ADDR_COUNTER      8'h80
`define MTC_ADDR_MODULO       8'h81
`define MTC_ADDR_CARR_HIGH    8'h82
`define MTC_ADDR_CARR_LOW     8'h83

// Field positions
`define MTC_BIT_RUN           3
`define MTC_BIT_CLEAR         2
`define MTC_BIT_CLKSEL_HI     1
`define MTC_BIT_CLKSEL_LO     0
`define MTC_BIT_IRQ_FLAG      0
`define MTC_BIT_GATE          0
`define MTC_BIT_SUPPRESS      1
`define MTC_BIT_GATE_BUF      0
`define MTC_BIT_SPEED         0

// Timer clock selections
`define MTC_TSEL_DIV32        2'h0
`define MTC_TSEL_DIV64        2'h1
`define MTC_TSEL_DIV256       2'h2
`define MTC_TSEL_CARRIER      2'h3

// Carrier clock selections
`define MTC_CSEL_HALF         2'h0
`define MTC_CSEL_FX           2'h1
`define MTC_CSEL_DOUBLE       2'h2

// Prescaler masks: a tick when the masked fx count is all ones
`define MTC_MASK_DIV16        8'h0F
`define MTC_MASK_DIV32        8'h1F
`define MTC_MASK_DIV64        8'h3F
`define MTC_MASK_DIV256       8'hFF

// Core clocks per carrier clock: core clock is the 2fx reference
`define MTC_CORE_PER_FX       2
`define MTC_CORE_PER_HALF_FX  4

// Reset values
`define MTC_RST_BYTE          8'h00
`define MTC_RST_CLKSEL        2'h0

`endif

// file: logic/mtc_tick_div.v
// Enable-pulse divider: one core-clock pulse every DIV clocks.
// Assumes a single clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module mtc_tick_div #(
  parameter DIV = 2,
  parameter W = 3
) (
  input wire core_clk_i,
  input wire reset_i,
  output wire tick_o
);

  reg [W-1:0] cnt_r;
  wire last;

  assign last = (cnt_r == DIV[W-1:0] - {{(W-1){1'b0}}, 1'b1});
  assign tick_o = last;

  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      cnt_r <= {W{1'b0}};
    end
    else if (last)
    begin
      cnt_r <= {W{1'b0}};
    end
    else
    begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// file: testbench/mtc_timer_carrier_assertions.sv
// Port checks for the interval timer and carrier generator.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module mtc_chk (
  input wire core_clk_i,
  input wire reset_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire irq_o,
  input wire interval_match_o,
  input wire carrier_out_pin_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  property p_rd_quiet; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero outside a reply");
  property p_mod_wo; $past(reg_rd_i && reg_addr_i == 8'h81) |-> reg_rdata_o == 8'h00; endproperty
  a_mod_wo: assert property (p_mod_wo) else $error("modulo register read back");
  property p_clr_wo; $past(reg_rd_i && reg_addr_i == 8'h33) |-> reg_rdata_o[7:4] == 4'h0 && !reg_rdata_o[2];
  endproperty
  a_clr_wo: assert property (p_clr_wo) else $error("clear bit or spare bits read back");
  property p_per_rb;
    (reg_wr_i && reg_addr_i == 8'h82) ##2 (reg_rd_i && reg_addr_i == 8'h82) |=> reg_rdata_o == $past(reg_wdata_i, 3);
  endproperty
  a_per_rb: assert property (p_per_rb) else $error("high period readback differs");
  // Shortest legal match period is four clocks, so three quiet cycles always follow
  property p_match_gap; interval_match_o |=> !interval_match_o [*3]; endproperty
  a_match_gap: assert property (p_match_gap) else $error("match pulses too close");
  property p_irq_rise; $rose(irq_o) |-> interval_match_o || $past(reg_wr_i && reg_addr_i == 8'h40); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without a match");
  property p_irq_fall;
    $fell(irq_o) |-> $past(reg_wr_i && (reg_addr_i == 8'h3F || reg_addr_i == 8'h40));
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without a write");
  property p_force_hi; reg_wr_i && reg_addr_i == 8'h12 && reg_wdata_i[1] |-> ##[2:3] carrier_out_pin_o; endproperty
  a_force_hi: assert property (p_force_hi) else $error("pin not forced high");
endmodule

// file: testbench/mtc_ir_led.sv
// Infrared LED load on the carrier pin; measures phase lengths.
// Assumes the pin is sampled on the core clock.
`timescale 1ns/1ps

module mtc_ir_led (
  input wire logic core_clk_i,
  input wire logic led_drive_i,
  output logic [9:0] high_len_o,
  output logic [9:0] low_len_o,
  output logic [7:0] pulse_cnt_o
);
  logic [9:0] run_r;
  logic last_r;
  ////////////////////////////////////////
  initial
  begin
    run_r = 10'h000;
    last_r = 1'h0;
    high_len_o = 10'h000;
    low_len_o = 10'h000;
    pulse_cnt_o = 8'h00;
  end
  // Length of each finished phase, in core clocks
  always @(posedge core_clk_i)
  begin
    last_r <= led_drive_i;
    run_r <= (led_drive_i != last_r) ? 10'h001 : run_r + 10'h001;
    if (last_r && !led_drive_i)
    begin
      high_len_o <= run_r;
      pulse_cnt_o <= pulse_cnt_o + 8'h01;
    end
    if (!last_r && led_drive_i)
      low_len_o <= run_r;
  end
endmodule

// file: testbench/mtc_testbench.sv
// Self-checking bench for the interval timer and carrier generator.
// Assumes design, checker and LED model are compiled before it.
`timescale 1ns/1ps
`include "mtc_map.vh"

module testbench;
  logic core_clk_i, reset_i, reg_wr_i, reg_rd_i, stop_mode_i, rd_q;
  logic [7:0] reg_addr_i, reg_wdata_i, pc;
  wire [7:0] reg_rdata_o, pulses;
  wire irq_o, interval_match_o, carrier_out_pin_o;
  wire [9:0] high_len, low_len;
  int err_count, checks_done, n, m, h, l;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [7:0] ra[12] = '{8'h02, 8'h11, 8'h12, 8'h13, 8'h33, 8'h3F, 8'h40, 8'h55, 8'h80, 8'h81, 8'h82, 8'h83};
  int tdiv[4] = '{32, 16, 64, 256};
  logic [7:0] tsel[4] = '{8'h00, 8'h00, 8'h01, 8'h02};
  int cmul[3] = '{4, 2, 1};
  mtc_timer_carrier dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .stop_mode_i(stop_mode_i), .irq_o(irq_o), .interval_match_o(interval_match_o),
    .carrier_out_pin_o(carrier_out_pin_o));
  mtc_ir_led led (.core_clk_i(core_clk_i), .led_drive_i(carrier_out_pin_o), .high_len_o(high_len),
    .low_len_o(low_len), .pulse_cnt_o(pulses));
  ////////////////////////////////////////
  initial
  begin
    core_clk_i = 1'h0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] x);
    checks_done++;
    if (seen !== x)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, x, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic guard(input int c);
    if (c >= 3000)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // A gap cycle between strobes keeps each strobe to one assignment per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] mk);
    exp_q.push_back({mk, x});
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'h0;
  endtask
  task automatic wr_irq(input logic [7:0] a, input logic [7:0] d, input logic x);
    wr(a, d);
    @(negedge core_clk_i);
    chk("irq level", {15'h0000, irq_o}, {15'h0000, x});
  endtask
  task automatic wait_match(output int c);
    c = 0;
    do
    begin
      @(negedge core_clk_i);
      c++;
    end while (interval_match_o !== 1'h1 && c < 3000);
    guard(c);
  endtask
  task automatic wait_pulses(input int k);
    pc = pulses;
    n = 0;
    while (8'(pulses - pc) < k && n < 3000)
    begin
      @(negedge core_clk_i);
      n++;
    end
    guard(n);
  endtask
  // Read replies are compared in the cycle after the strobe
  always @(posedge core_clk_i) rd_q <= reg_rd_i;
  always @(negedge core_clk_i)
    if (rd_q === 1'h1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      chk("read data", {8'h00, reg_rdata_o & e[15:8]}, {8'h00, e[7:0]});
    end
  ////////////////////////////////////////
  initial
  begin
    reset_i = 1'h1;
    reg_wr_i = 1'h0;
    reg_rd_i = 1'h0;
    stop_mode_i = 1'h0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    n = $urandom(59);
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'h0;
    foreach (ra[i]) rd(ra[i], 8'h00, 8'hFF);
    $display("test reset values done");
    h = $urandom % 256;
    wr(8'h82, 8'(h));
    rd(8'h82, 8'(h), 8'hFF);
    l = $urandom % 256;
    wr(8'h83, 8'(l));
    rd(8'h83, 8'(l), 8'hFF);
    wr(8'h81, 8'h5A);
    rd(8'h81, 8'h00, 8'hFF);
    wr(8'h13, 8'hFF);
    rd(8'h13, 8'h03, 8'hFF);
    wr(8'h33, 8'h07);
    rd(8'h33, 8'h03, 8'hFF);
    wr(8'h80, 8'h55);
    rd(8'h80, 8'h00, 8'hFF);
    $display("test registers done");
    wr(8'h40, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      m = $urandom % 3 + 1;
      wr(8'h33, 8'h04);
      wr(8'h02, {7'h00, i == 1});
      wr(8'h81, 8'(m));
      wr(8'h33, 8'h0C | tsel[i]);
      wait_match(n);
      wait_match(n);
      chk("match period", 16'(n), 16'((m + 1) * tdiv[i] * 2));
      chk("irq level", {15'h0000, irq_o}, 16'h0001);
    end
    wr(8'h33, 8'h04);
    rd(8'h3F, 8'h01, 8'hFF);
    wr_irq(8'h40, 8'h00, 1'h0);
    wr_irq(8'h40, 8'h01, 1'h1);
    wr_irq(8'h3F, 8'h01, 1'h0);
    wr(8'h33, 8'h08);
    @(posedge core_clk_i);
    stop_mode_i <= 1'h1;
    @(posedge core_clk_i);
    stop_mode_i <= 1'h0;
    rd(8'h33, 8'h00, 8'h08);
    $display("test timer done");
    for (int i = 0; i < 3; i++)
    begin
      h = $urandom % 8;
      l = $urandom % 8;
      wr(8'h12, 8'h00);
      wr(8'h82, 8'(h));
      wr(8'h83, 8'(l));
      wr(8'h13, 8'(i));
      wr(8'h12, 8'h01);
      wait_pulses(3);
      chk("high phase", 16'(high_len), 16'((h + 1) * cmul[i]));
      chk("low phase", 16'(low_len), 16'((l + 1) * cmul[i]));
    end
    wr(8'h12, 8'h00);
    repeat (100) @(negedge core_clk_i);
    pc = pulses;
    repeat (100) @(negedge core_clk_i);
    chk("pin idle", {15'h0000, carrier_out_pin_o}, 16'h0000);
    chk("pulses halted", 16'(8'(pulses - pc)), 16'h0000);
    wr(8'h12, 8'h02);
    repeat (4) @(negedge core_clk_i);
    chk("pin forced", {15'h0000, carrier_out_pin_o}, 16'h0001);
    wr(8'h12, 8'h00);
    $display("test carrier done");
    // Timer counting carrier periods: buffer stays 1 so each match keeps the gate on
    wr(8'h11, 8'h01);
    wr(8'h82, 8'h01);
    wr(8'h83, 8'h01);
    wr(8'h13, 8'h02);
    wr(8'h12, 8'h01);
    wr(8'h81, 8'h03);
    wr(8'h33, 8'h0F);
    wait_match(n);
    wait_match(n);
    chk("carrier timer period", 16'(n), 16'h0010);
    wr(8'h33, 8'h04);
    wr(8'h12, 8'h00);
    $display("test carrier clocked timer done");
    wr(8'h82, 8'h07);
    wr(8'h83, 8'h03);
    wr(8'h13, 8'h00);
    wr(8'h11, 8'h01);
    wr(8'h81, 8'h01);
    wr(8'h33, 8'h0C);
    wait_pulses(2);
    wr(8'h11, 8'h00);
    wait_match(n);
    repeat (60) @(negedge core_clk_i);
    chk("pin after gate copy", {15'h0000, carrier_out_pin_o}, 16'h0000);
    chk("last high phase", 16'(high_len), 16'h0020);
    $display("test gate buffer done");
    tally_and_finish();
  end
endmodule

bind mtc_timer_carrier mtc_chk u_chk (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .irq_o(irq_o), .interval_match_o(interval_match_o), .carrier_out_pin_o(carrier_out_pin_o));
